// ---- common/trunk_regs_pkg.sv ----
// Constants and carrier types for the trunk loopback / elastic store / signaling register bank.
// Assumes an AHB-Lite master on hclk; one register per aligned 32-bit word.
package trunk_regs_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_LOOP_1_8 = 8'h4b;
	localparam logic [7:0] IDX_LOOP_9_16 = 8'h4c;
	localparam logic [7:0] IDX_LOOP_17_24 = 8'h4d;
	localparam logic [7:0] IDX_LOOP_25_32 = 8'h4e;
	localparam logic [7:0] IDX_STORE_CTRL = 8'h4f;
	localparam logic [7:0] IDX_SIG_FIRST = 8'h50;
	localparam logic [7:0] IDX_SIG_LAST = 8'h5f;
	localparam logic [7:0] IDX_STORE_STATUS = 8'h40;
	localparam logic [7:0] IDX_SIG_MODE = 8'h41;
	localparam int ADDR_LSB = 2;
	localparam int NUM_CHAN = 32;
	localparam int NUM_SIG = 16;
	// Control bit positions
	localparam int BIT_TX_ALIGN = 7;
	localparam int BIT_TX_RESET = 6;
	localparam int BIT_TX_MIN_DELAY = 5;
	localparam int BIT_TX_ENABLE = 4;
	localparam int BIT_RX_ALIGN = 3;
	localparam int BIT_RX_RESET = 2;
	localparam int BIT_RX_MIN_DELAY = 1;
	localparam int BIT_RX_ENABLE = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Store geometry in bits: two frames of 32 timeslots
	localparam int FRAME_BITS = 256;
	localparam int PTR_W = 9;
	localparam logic [PTR_W-1:0] FULL_DEPTH = 9'h1ff;
	localparam logic [PTR_W-1:0] MIN_DEPTH = 9'h01f;
	localparam logic [PTR_W-1:0] HALF_FRAME = 9'h080;
	localparam logic [PTR_W-1:0] ONE_FRAME = 9'h100;
	localparam logic [PTR_W-1:0] MIN_HALF = 9'h010;
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		SIG_E1_CAS = 2'b00,
		SIG_E1_CCS = 2'b01,
		SIG_T1_ESF = 2'b10
	} sig_mode_t;

	// One direction of the serial data path: bit, write strobe, read strobe
	typedef struct packed {
		logic data;
		logic wr;
		logic rd;
	} bit_path_t;

	typedef struct packed {
		logic [3:0] abcd;
		logic [4:0] chan;
	} sig_pick_t;
endpackage

// ---- hw/trunk_loopback_elastic_signaling_regs.sv ----
// Register bank with per-channel payload loopback on the transmit bypass path, two elastic stores and the
// transmit signaling map. Assumes AHB-Lite master on hclk; serial data strobes
// come from framer logic on the same clock.
`timescale 1ns/10ps
module trunk_loopback_elastic_signaling_regs #(
	parameter int NUM_CHAN_P = 32
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [4:0] tx_chan,
	input wire logic tx_sys_bit,
	input wire logic rx_line_bit,
	input wire trunk_regs_pkg::bit_path_t tx_store_path,
	input wire trunk_regs_pkg::bit_path_t rx_store_path,
	output logic tx_line_bit,
	output logic rx_sys_bit,
	input wire trunk_regs_pkg::sig_mode_t sig_mode,
	input wire logic [4:0] sig_chan,
	output trunk_regs_pkg::sig_pick_t sig_pick,
	output logic [6:0] sig_ccs_sel_out
);
	import trunk_regs_pkg::*;

	logic [7:0] loop_en [4];
	logic [7:0] store_ctrl;
	logic [7:0] sig_byte [NUM_SIG];
	logic [7:0] prev_ctrl;
	logic wr_pend;
	logic [7:0] wr_idx;
	logic [PTR_W-1:0] tx_wptr, tx_rptr, rx_wptr, rx_rptr;
	logic tx_mem [FRAME_BITS*2];
	logic rx_mem [FRAME_BITS*2];
	logic tx_out_q, rx_out_q;
	logic [7:0] rd_byte;

	// Address phase decode
	wire addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
	wire [7:0] a_idx = haddr[ADDR_LSB+7:ADDR_LSB];
	wire is_loop = (wr_idx >= IDX_LOOP_1_8) && (wr_idx <= IDX_LOOP_25_32);
	wire is_sig = (wr_idx >= IDX_SIG_FIRST) && (wr_idx <= IDX_SIG_LAST);
	wire [1:0] loop_sel = 2'(wr_idx - IDX_LOOP_1_8);
	wire [3:0] sig_sel = 4'(wr_idx - IDX_SIG_FIRST);
	wire do_wr = wr_pend && clk_en;
	wire [7:0] wdat = hwdata[7:0];

	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Read mux on the address phase so data is registered for the data phase
	wire r_loop = (a_idx >= IDX_LOOP_1_8) && (a_idx <= IDX_LOOP_25_32);
	wire r_sig = (a_idx >= IDX_SIG_FIRST) && (a_idx <= IDX_SIG_LAST);
	wire [1:0] r_lsel = 2'(a_idx - IDX_LOOP_1_8);
	wire [3:0] r_ssel = 4'(a_idx - IDX_SIG_FIRST);
	wire [PTR_W-1:0] tx_sep = tx_wptr - tx_rptr;
	wire [PTR_W-1:0] rx_sep = rx_wptr - rx_rptr;
	always_comb begin
		if (r_loop) begin
			rd_byte = loop_en[r_lsel];
		end else if (a_idx == IDX_STORE_CTRL) begin
			rd_byte = store_ctrl;
		end else if (r_sig) begin
			rd_byte = sig_byte[r_ssel];
		end else if (a_idx == IDX_STORE_STATUS) begin
			// Separation at or above half frame, per direction
			rd_byte = {6'h00, rx_sep >= HALF_FRAME, tx_sep >= HALF_FRAME};
		end else begin
			rd_byte = RESET_BYTE; // Unmapped reads as zero
		end
	end

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_idx <= 8'h00;
			hrdata <= WORD_ZERO;
		end else if (clk_en) begin
			wr_pend <= addr_ok && hwrite;
			wr_idx <= a_idx;
			if (addr_ok && !hwrite) begin
				hrdata <= {24'h000000, rd_byte};
			end
		end
	end

	// Loopback banks: bank n holds channels 8n+1..8n+8, bit0 lowest
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_loop
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					loop_en[g] <= RESET_BYTE;
				end else if (do_wr && is_loop && loop_sel == 2'(g)) begin
					loop_en[g] <= wdat;
				end
			end
		end
		// Signaling bytes; no reset value is defined, cleared for determinism
		for (g = 0; g < NUM_SIG; g++) begin : g_sig
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sig_byte[g] <= RESET_BYTE;
				end else if (do_wr && is_sig && sig_sel == 4'(g)) begin
					sig_byte[g] <= wdat;
				end
			end
		end
	endgenerate

	// Elastic store control and previous value for edge detection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			store_ctrl <= RESET_BYTE;
			prev_ctrl <= RESET_BYTE;
		end else if (clk_en) begin
			prev_ctrl <= store_ctrl;
			if (do_wr && wr_idx == IDX_STORE_CTRL) begin
				store_ctrl <= wdat;
			end
		end
	end

	// Commands fire only on a fresh rise; holding a bit high does nothing more
	wire tx_align_cmd = store_ctrl[BIT_TX_ALIGN] && !prev_ctrl[BIT_TX_ALIGN];
	wire tx_reset_cmd = store_ctrl[BIT_TX_RESET] && !prev_ctrl[BIT_TX_RESET];
	wire rx_align_cmd = store_ctrl[BIT_RX_ALIGN] && !prev_ctrl[BIT_RX_ALIGN];
	wire rx_reset_cmd = store_ctrl[BIT_RX_RESET] && !prev_ctrl[BIT_RX_RESET];
	wire [PTR_W-1:0] tx_depth = store_ctrl[BIT_TX_MIN_DELAY] ? MIN_DEPTH : FULL_DEPTH;
	wire [PTR_W-1:0] rx_depth = store_ctrl[BIT_RX_MIN_DELAY] ? MIN_DEPTH : FULL_DEPTH;
	// In minimum-delay mode the "half" target shrinks to half the 32-bit store
	wire [PTR_W-1:0] tx_half = store_ctrl[BIT_TX_MIN_DELAY] ? MIN_HALF : HALF_FRAME;
	wire [PTR_W-1:0] rx_half = store_ctrl[BIT_RX_MIN_DELAY] ? MIN_HALF : HALF_FRAME;
	wire [PTR_W-1:0] tx_sep_m = tx_sep & tx_depth;
	wire [PTR_W-1:0] rx_sep_m = rx_sep & rx_depth;
	wire [PTR_W-1:0] tx_opp = store_ctrl[BIT_TX_MIN_DELAY] ? MIN_HALF : ONE_FRAME;
	wire [PTR_W-1:0] rx_opp = store_ctrl[BIT_RX_MIN_DELAY] ? MIN_HALF : ONE_FRAME;

	// Transmit store pointers; reset outranks align
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_wptr <= '0;
			tx_rptr <= '0;
		end else if (clk_en) begin
			if (tx_reset_cmd) begin
				tx_wptr <= '0;
				tx_rptr <= tx_opp;
			end else if (tx_align_cmd && tx_sep_m < tx_half) begin
				tx_rptr <= (tx_wptr - tx_half) & tx_depth;
				tx_wptr <= (tx_wptr + (tx_store_path.wr ? 9'h001 : 9'h000)) & tx_depth;
			end else begin
				tx_wptr <= (tx_wptr + (tx_store_path.wr ? 9'h001 : 9'h000)) & tx_depth;
				tx_rptr <= (tx_rptr + (tx_store_path.rd ? 9'h001 : 9'h000)) & tx_depth;
			end
		end
	end

	// Receive store pointers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_wptr <= '0;
			rx_rptr <= '0;
		end else if (clk_en) begin
			if (rx_reset_cmd) begin
				rx_wptr <= '0;
				rx_rptr <= rx_opp;
			end else if (rx_align_cmd && rx_sep_m < rx_half) begin
				rx_rptr <= (rx_wptr - rx_half) & rx_depth;
				rx_wptr <= (rx_wptr + (rx_store_path.wr ? 9'h001 : 9'h000)) & rx_depth;
			end else begin
				rx_wptr <= (rx_wptr + (rx_store_path.wr ? 9'h001 : 9'h000)) & rx_depth;
				rx_rptr <= (rx_rptr + (rx_store_path.rd ? 9'h001 : 9'h000)) & rx_depth;
			end
		end
	end

	// Store arrays; tx writes are dropped during reset, so data is lost
	always_ff @(posedge hclk) begin
		if (clk_en) begin
			if (tx_store_path.wr && !tx_reset_cmd) begin
				tx_mem[tx_wptr] <= tx_store_path.data;
			end
			if (rx_store_path.wr) begin
				rx_mem[rx_wptr] <= rx_store_path.data;
			end
		end
	end

	// Per-channel source pick for the transmit bypass, not the store input: only the current slot
	wire tx_lb = loop_en[tx_chan[4:3]][tx_chan[2:0]];
	wire tx_src = tx_lb ? rx_line_bit : tx_sys_bit;

	// Registered outputs; bypass when the store is off
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_out_q <= 1'b0;
			rx_out_q <= 1'b0;
		end else if (clk_en) begin
			tx_out_q <= store_ctrl[BIT_TX_ENABLE] ? tx_mem[tx_rptr] : tx_src;
			rx_out_q <= store_ctrl[BIT_RX_ENABLE] ? rx_mem[rx_rptr] : rx_line_bit;
		end
	end
	assign tx_line_bit = tx_out_q;
	assign rx_sys_bit = rx_out_q;

	// Signaling lookup for the channel being sent
	wire [4:0] cas_ch = sig_chan - 5'd1;
	wire [3:0] cas_idx = 4'(cas_ch[4:1]) + 4'd1;
	wire [3:0] esf_idx = 4'(cas_ch[4:1]);
	wire [3:0] pick_idx = (sig_mode == SIG_T1_ESF) ? esf_idx : cas_idx;
	wire [7:0] pick_byte = sig_byte[pick_idx];
	wire [3:0] nib = cas_ch[0] ? pick_byte[7:4] : pick_byte[3:0];
	// CCS: bit n sits at byte (n-1)/8, MSB first
	wire [6:0] ccs_n = {2'b00, sig_chan};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sig_pick <= '0;
			sig_ccs_sel_out <= 7'h00;
		end else if (clk_en) begin
			sig_pick.chan <= sig_chan;
			// CCS: nibble k holds bits 4k+1..4k+4, even k in the upper half
			if (sig_mode == SIG_E1_CCS) begin
				sig_pick.abcd <= sig_chan[0] ? sig_byte[sig_chan[4:1]][3:0]
					: sig_byte[sig_chan[4:1]][7:4];
			end else begin
				sig_pick.abcd <= nib;
			end
			sig_ccs_sel_out <= ccs_n;
		end
	end
endmodule

// ---- verif/trunk_regs_chk.sv ----
// Port checker for the trunk register bank.
// Assumes single AHB-Lite transfers on hclk and hready tied to hreadyout.
`timescale 1ns/10ps
module trunk_regs_chk
import trunk_regs_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [4:0] tx_chan,
	input wire logic tx_sys_bit,
	input wire logic rx_line_bit,
	input wire logic tx_line_bit,
	input wire logic rx_sys_bit
);
	logic wp;
	logic [7:0] wi;
	logic [7:0] ctl;
	logic [3:0][7:0] lp;
	// Decode of the current address phase
	wire [7:0] ix = haddr[9:2];
	wire rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && clk_en;
	wire unm = ix != IDX_STORE_STATUS && (ix < IDX_LOOP_1_8 || ix > IDX_SIG_LAST);
	wire lb = lp[2'(tx_chan[4:3] + 2'd3)][tx_chan[2:0]];
	// Shadow of control and loopback bytes, so outputs can be tied to register state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wp <= 1'b0;
			wi <= 8'h00;
			ctl <= 8'h00;
			lp <= '0;
		end else if (clk_en) begin
			wp <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			wi <= ix;
			if (wp && wi == IDX_STORE_CTRL) ctl <= hwdata[7:0];
			if (wp && wi >= IDX_LOOP_1_8 && wi <= IDX_LOOP_25_32) lp[wi[1:0]] <= hwdata[7:0];
		end
	end
	AST_READY_ONE: assert property (@(posedge hclk) disable iff (!hresetn) hreadyout)
		else $error("hreadyout low");
	AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn) !hresp)
		else $error("hresp not okay");
	AST_RDATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
		!rd |=> $stable(hrdata)) else $error("hrdata moved without a read");
	AST_UNMAPPED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		rd && unm |=> hrdata == WORD_ZERO) else $error("unmapped read not zero");
	AST_CTRL_READBACK: assert property (@(posedge hclk) disable iff (!hresetn)
		rd && ix == IDX_STORE_CTRL |=> hrdata == {24'h0, ctl}) else $error("control readback");
	AST_LOOP_READBACK: assert property (@(posedge hclk) disable iff (!hresetn)
		rd && ix >= IDX_LOOP_1_8 && ix <= IDX_LOOP_25_32 |=> hrdata == {24'h0, lp[$past(ix[1:0])]})
		else $error("loopback readback");
	AST_RX_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en |=> $past(ctl[BIT_RX_ENABLE]) || rx_sys_bit == $past(rx_line_bit))
		else $error("rx bypass");
	AST_TX_BYPASS: assert property (@(posedge hclk) disable iff (!hresetn)
		clk_en |=> $past(ctl[BIT_TX_ENABLE]) || $past(lb) || tx_line_bit == $past(tx_sys_bit))
		else $error("tx bypass");
endmodule
bind trunk_loopback_elastic_signaling_regs trunk_regs_chk trunk_regs_chk_i (.hclk, .hresetn,
	.clk_en, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
	.tx_chan, .tx_sys_bit, .rx_line_bit, .tx_line_bit, .rx_sys_bit);

// ---- verif/testbench.sv ----
// Self-checking bench for the trunk register bank over AHB-Lite.
// Drives all ports itself; the stores see no serial strobes.
`timescale 1ns/10ps
module testbench;
	import trunk_regs_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
	logic [1:0] htrans = 2'b00;
	logic [4:0] tx_chan = '0, sig_chan = 5'd1;
	logic tx_sys_bit = 1'b0, rx_line_bit = 1'b0, tx_line_bit, rx_sys_bit, hreadyout, hresp;
	logic [6:0] ccs;
	sig_mode_t sig_mode = SIG_E1_CAS;
	sig_pick_t sig_pick;
	int err_count = 0, compares = 0, cyc = 0;
	initial begin
		forever #5 hclk = ~hclk;
	end
	trunk_loopback_elastic_signaling_regs trunk_loopback_elastic_signaling_regs_i (
		.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tx_chan(tx_chan), .tx_sys_bit(tx_sys_bit), .rx_line_bit(rx_line_bit),
		.tx_store_path('0), .rx_store_path('0), .tx_line_bit(tx_line_bit),
		.rx_sys_bit(rx_sys_bit), .sig_mode(sig_mode), .sig_chan(sig_chan),
		.sig_pick(sig_pick), .sig_ccs_sel_out(ccs));
	task automatic close_out();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single transfer; holds each phase until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		xfer(1'b0, idx, 8'h00);
		chk(q, {24'h0, e});
	endtask
	// Registered nibble needs a few cycles once mode and channel are held
	task automatic sig(input sig_mode_t m, input logic [4:0] c, input logic [3:0] e);
		@(posedge hclk);
		sig_mode <= m;
		sig_chan <= c;
		repeat (3) @(posedge hclk);
		chk({28'h0, sig_pick.abcd}, {28'h0, e});
		chk({27'h0, sig_pick.chan}, {27'h0, c});
		chk({25'h0, ccs}, {27'h0, c});
	endtask
	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 5; i++) rd(IDX_LOOP_1_8 + 8'(i), 8'h00);
		xfer(1'b1, IDX_SIG_MODE, 8'hff);
		rd(IDX_SIG_MODE, 8'h00);
		// One channel per bank, at bits 0, 7, 3 and 7, so order and bank mix-ups show
		xfer(1'b1, IDX_LOOP_1_8, 8'h01);
		xfer(1'b1, IDX_LOOP_9_16, 8'h80);
		xfer(1'b1, IDX_LOOP_17_24, 8'h08);
		xfer(1'b1, IDX_LOOP_25_32, 8'h80);
		rd(IDX_LOOP_17_24, 8'h08);
		rx_line_bit <= 1'b1;
		for (int c = 0; c < NUM_CHAN; c++) begin
			tx_chan <= 5'(c);
			repeat (3) @(posedge hclk);
			chk({31'h0, tx_line_bit}, {31'h0, (c inside {0, 15, 19, 31})});
		end
		rx_line_bit <= 1'b0;
		repeat (3) @(posedge hclk);
		chk({31'h0, rx_sys_bit}, 32'h0);
		clk_en <= 1'b0;
		rx_line_bit <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, rx_sys_bit}, 32'h0);
		clk_en <= 1'b1;
		repeat (3) @(posedge hclk);
		chk({31'h0, rx_sys_bit}, 32'h1);
		// Align both stores from rest, then reset mid-run and use the reset commands
		xfer(1'b1, IDX_STORE_CTRL, 8'h88);
		repeat (3) @(posedge hclk);
		rd(IDX_STORE_STATUS, 8'h03);
		// Re-arm and align again while already apart: pointers must stay put
		xfer(1'b1, IDX_STORE_CTRL, 8'h00);
		xfer(1'b1, IDX_STORE_CTRL, 8'h88);
		repeat (3) @(posedge hclk);
		rd(IDX_STORE_STATUS, 8'h03);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rd(IDX_STORE_CTRL, 8'h00);
		xfer(1'b1, IDX_STORE_CTRL, 8'h44);
		repeat (3) @(posedge hclk);
		rd(IDX_STORE_STATUS, 8'h03);
		xfer(1'b1, IDX_STORE_CTRL, 8'h33);
		rd(IDX_STORE_CTRL, 8'h33);
		xfer(1'b1, IDX_STORE_CTRL, 8'h00);
		// Signaling bytes: first, second and last
		xfer(1'b1, IDX_SIG_FIRST, 8'h3c);
		xfer(1'b1, IDX_SIG_FIRST + 8'h01, 8'ha5);
		xfer(1'b1, IDX_SIG_LAST, 8'h96);
		rd(IDX_SIG_LAST, 8'h96);
		sig(SIG_E1_CAS, 5'd1, 4'h5);
		sig(SIG_E1_CAS, 5'd2, 4'ha);
		sig(SIG_E1_CAS, 5'd29, 4'h6);
		sig(SIG_E1_CAS, 5'd30, 4'h9);
		sig(SIG_T1_ESF, 5'd1, 4'hc);
		sig(SIG_T1_ESF, 5'd2, 4'h3);
		sig(SIG_E1_CCS, 5'd0, 4'h3);
		sig(SIG_E1_CCS, 5'd1, 4'hc);
		sig(SIG_E1_CCS, 5'd31, 4'h6);
		close_out();
	end
endmodule
